// ==== gpe_edge_det.sv ====
// per-pin input sampler and qualified edge detector.
// assumes pin levels are synchronous to CLK.
`timescale 1ns/1ps
module gpe_edge_det #(
  parameter int unsigned W     = 32,
  parameter int unsigned ACT   = 2,
  parameter int unsigned INACT = 1
) (
  input  wire logic         CLK,
  input  wire logic         RESET,
  input  wire logic [W-1:0] smp_in,
  output logic [W-1:0]      level,
  output logic [W-1:0]      rise,
  output logic [W-1:0]      fall
);

  localparam int unsigned H = ACT + INACT;

  typedef struct packed {
    logic [H-1:0][W-1:0] hist;
  } gpe_ed_st_t;

  gpe_ed_st_t st_reg;
  gpe_ed_st_t st_next;

  initial begin
    if (W < 1 || ACT < 1 || INACT < 1)
      $error("gpe_edge_det: bad width or pulse counts");
  end

  always_comb begin
    st_next = st_reg;
    st_next.hist[0] = smp_in;
    for (int i = 1; i < H; i++) begin
      st_next.hist[i] = st_reg.hist[i-1];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.hist[0];

  // an edge counts only after ACT equal samples preceded by INACT opposite
  for (genvar b = 0; b < W; b++) begin : g_bit
    logic [H-1:0] h;
    for (genvar k = 0; k < H; k++) begin : g_tap
      assign h[k] = st_reg.hist[k][b];
    end
    assign rise[b] = (&h[ACT-1:0]) & ~(|h[H-1:ACT]);
    assign fall[b] = ~(|h[ACT-1:0]) & (&h[H-1:ACT]);
  end

endmodule : gpe_edge_det

// ==== gpe_pad_model.sv ====
// pad model: port drive, then outside source, then pull-down, else the inverse of ext_val sets each level.
// assumes the bench drives the outside source.
`timescale 1ns/1ps
module gpe_pad_model (
  input  wire gpe_pkg::gpe_pins_t        pins,
  input  wire logic [gpe_pkg::NPINS-1:0] ext_en,
  input  wire logic [gpe_pkg::NPINS-1:0] ext_val,
  output logic [gpe_pkg::NPINS-1:0]      pin_lvl
);
  always_comb begin
    for (int i = 0; i < gpe_pkg::NPINS; i++) begin
      if (pins.oe[i])
        pin_lvl[i] = pins.out[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_val[i];
      else
        pin_lvl[i] = ~pins.pd_en[i] & ~ext_val[i];
    end
  end
endmodule : gpe_pad_model

// ==== gpe_pkg.sv ====
// package for the general-purpose pin port: offsets, reset values,
// timing counts and the structs that carry bus and pin groups.
// assumes a 40 MHz system clock and a byte-addressed register port.
package gpe_pkg;

  localparam int unsigned NPINS = 32;
  localparam int unsigned AW    = 6;
  localparam int unsigned DW    = 32;

  // register byte offsets
  localparam logic [AW-1:0] OFS_DIR  = 6'h00;
  localparam logic [AW-1:0] OFS_DOUT = 6'h04;
  localparam logic [AW-1:0] OFS_DIN  = 6'h08;
  localparam logic [AW-1:0] OFS_POL  = 6'h0c;
  localparam logic [AW-1:0] OFS_IFR  = 6'h10;
  localparam logic [AW-1:0] OFS_IER  = 6'h14;
  localparam logic [AW-1:0] OFS_PDD  = 6'h18;
  localparam logic [AW-1:0] OFS_XTRA = 6'h1c;
  localparam logic [AW-1:0] OFS_SET  = 6'h20;
  localparam logic [AW-1:0] OFS_CLR  = 6'h24;

  // field positions
  localparam int unsigned XTRA_BIT = 0;

  // reset values
  localparam logic [DW-1:0] RST_DIR  = 32'h0000_0000;
  localparam logic [DW-1:0] RST_DOUT = 32'h0000_0000;
  localparam logic [DW-1:0] RST_POL  = 32'h0000_0000;
  localparam logic [DW-1:0] RST_IFR  = 32'h0000_0000;
  localparam logic [DW-1:0] RST_IER  = 32'h0000_0000;
  localparam logic [DW-1:0] RST_PDD  = 32'h0000_0000;
  localparam logic          RST_XTRA = 1'h0;
  localparam logic [DW-1:0] RD_ZERO  = 32'h0000_0000;

  // timing: pulse widths in ns, then cycles rounded up
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned ACT_MIN_NS  = 2 * CLK_NS;
  localparam int unsigned INACT_MIN_NS = 1 * CLK_NS;
  localparam int unsigned ACT_CYC =
    (ACT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned INACT_CYC =
    (INACT_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } gpe_req_t;

  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] pd_en;
  } gpe_pins_t;

  typedef struct packed {
    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] dout;
    logic [NPINS-1:0] pol;
    logic [NPINS-1:0] ifr;
    logic [NPINS-1:0] ier;
    logic [NPINS-1:0] pdd;
    logic             xtra;
    logic [DW-1:0]    rdata;
    gpe_pins_t        pins;
    logic             irq;
  } gpe_st_t;

endpackage : gpe_pkg

// ==== gpe_port.sv ====
// general-purpose pin port: direction, output data, input sampling,
// per-pin edge interrupts with mask, pull-down control, extra output.
// assumes a single-cycle register port and pins synchronous to CLK.
//
// Summary of operation
// - each pin is set as input or output by its direction bit
// - an output pin drives the bit software wrote to the output register
// - reading the input register returns the sampled level of input pins
// - each pin raises an edge interrupt, rising or falling chosen per pin
// - each pin interrupt has its own enable bit
// - pull-downs are on after reset, each one can be switched off
// - thirty-two two-way pins plus one output-only pin under software
// - many pins, at least twenty, update in a single register access
// - a qualifying pulse sets its flag and raises an interrupt
// - port function applies only to pins the multiplexer selects; reset sets the pull-down enable of every pin, selected or not
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module gpe_port #(
  parameter int unsigned N_PINS = gpe_pkg::NPINS
) (
  input  wire logic                       CLK,
  input  wire logic                       RESET,
  input  wire gpe_pkg::gpe_req_t          REG_REQ,
  output logic [gpe_pkg::DW-1:0]          REG_RDATA,
  input  wire logic [gpe_pkg::NPINS-1:0]  PIN_IN,
  input  wire logic [gpe_pkg::NPINS-1:0]  PIN_SEL,
  output gpe_pkg::gpe_pins_t              PINS,
  output logic                            EXTRA_OUTPUT_PIN,
  output logic                            IRQ
);

  localparam int unsigned NP = gpe_pkg::NPINS;

  // pins beyond N_PINS stay idle
  localparam logic [NP-1:0] PIN_MASK =
    NP'((64'h1 << N_PINS) - 64'h1);

  initial begin
    if (N_PINS < 1 || N_PINS > gpe_pkg::NPINS)
      $error("gpe_port: N_PINS out of range");
  end

  gpe_pkg::gpe_st_t st_reg;
  gpe_pkg::gpe_st_t st_next;

  logic [NP-1:0] smp_level;
  logic [NP-1:0] smp_rise;
  logic [NP-1:0] smp_fall;

  // inputs are only meaningful on selected pins set as inputs
  logic [NP-1:0] in_live;
  logic [NP-1:0] pin_evt;

  gpe_edge_det #(
    .W     (NP),
    .ACT   (gpe_pkg::ACT_CYC),
    .INACT (gpe_pkg::INACT_CYC)
  ) u_edge (
    .CLK    (CLK),
    .RESET  (RESET),
    .smp_in (PIN_IN),
    .level  (smp_level),
    .rise   (smp_rise),
    .fall   (smp_fall)
  );

  assign in_live = ~st_reg.dir & PIN_SEL & PIN_MASK;

  // polarity bit one selects the falling edge
  assign pin_evt = in_live &
    ((smp_rise & ~st_reg.pol) | (smp_fall & st_reg.pol));

  logic wr_hit;
  logic rd_hit;
  logic [gpe_pkg::DW-1:0] wd;
  logic [gpe_pkg::AW-1:0] ad;

  assign wr_hit = REG_REQ.wr;
  assign rd_hit = REG_REQ.rd;
  assign wd     = REG_REQ.wdata;
  assign ad     = REG_REQ.addr;

  always_comb begin
    logic [NP-1:0] w1c;
    w1c = '0;
    st_next = st_reg;

    // register writes
    if (wr_hit) begin
      case (ad)
        gpe_pkg::OFS_DIR: begin
          st_next.dir = wd[NP-1:0] & PIN_MASK;
        end
        gpe_pkg::OFS_DOUT: begin
          st_next.dout = wd[NP-1:0] & PIN_MASK;
        end
        gpe_pkg::OFS_POL: begin
          st_next.pol = wd[NP-1:0] & PIN_MASK;
        end
        gpe_pkg::OFS_IFR: begin
          w1c = wd[NP-1:0];
        end
        gpe_pkg::OFS_IER: begin
          st_next.ier = wd[NP-1:0] & PIN_MASK;
        end
        gpe_pkg::OFS_PDD: begin
          st_next.pdd = wd[NP-1:0] & PIN_MASK;
        end
        gpe_pkg::OFS_XTRA: begin
          st_next.xtra = wd[gpe_pkg::XTRA_BIT];
        end
        gpe_pkg::OFS_SET: begin
          st_next.dout = st_reg.dout | (wd[NP-1:0] & PIN_MASK);
        end
        gpe_pkg::OFS_CLR: begin
          st_next.dout = st_reg.dout & ~wd[NP-1:0];
        end
        default: begin
          st_next.dir = st_reg.dir;
        end
      endcase
    end

    // sticky flags: a new event wins over a clear in the same cycle
    st_next.ifr = (st_reg.ifr & ~w1c) | pin_evt;

    // read data stand only in the cycle after the strobe
    st_next.rdata = gpe_pkg::RD_ZERO;
    if (rd_hit) begin
      case (ad)
        gpe_pkg::OFS_DIR: begin
          st_next.rdata = gpe_pkg::DW'(st_reg.dir);
        end
        gpe_pkg::OFS_DOUT: begin
          st_next.rdata = gpe_pkg::DW'(st_reg.dout);
        end
        gpe_pkg::OFS_DIN: begin
          st_next.rdata = gpe_pkg::DW'(smp_level & in_live);
        end
        gpe_pkg::OFS_POL: begin
          st_next.rdata = gpe_pkg::DW'(st_reg.pol);
        end
        gpe_pkg::OFS_IFR: begin
          st_next.rdata = gpe_pkg::DW'(st_reg.ifr);
        end
        gpe_pkg::OFS_IER: begin
          st_next.rdata = gpe_pkg::DW'(st_reg.ier);
        end
        gpe_pkg::OFS_PDD: begin
          st_next.rdata = gpe_pkg::DW'(st_reg.pdd);
        end
        gpe_pkg::OFS_XTRA: begin
          st_next.rdata[gpe_pkg::XTRA_BIT] = st_reg.xtra;
        end
        default: begin
          st_next.rdata = gpe_pkg::RD_ZERO;
        end
      endcase
    end

    // pin drivers follow the registers, updated on the same edge
    st_next.pins.oe =
      st_next.dir & PIN_SEL & PIN_MASK;
    st_next.pins.out = st_next.dout & st_next.pins.oe;
    st_next.pins.pd_en =
      ~st_next.pdd & PIN_SEL & PIN_MASK;

    // level request while any enabled flag is set
    st_next.irq = |(st_next.ifr & st_next.ier);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_reg.dir        <= gpe_pkg::RST_DIR;
      st_reg.dout       <= gpe_pkg::RST_DOUT;
      st_reg.pol        <= gpe_pkg::RST_POL;
      st_reg.ifr        <= gpe_pkg::RST_IFR;
      st_reg.ier        <= gpe_pkg::RST_IER;
      st_reg.pdd        <= gpe_pkg::RST_PDD;
      st_reg.xtra       <= gpe_pkg::RST_XTRA;
      st_reg.rdata      <= gpe_pkg::RD_ZERO;
      st_reg.pins.out   <= '0;
      st_reg.pins.oe    <= '0;
      st_reg.pins.pd_en <= '1;
      st_reg.irq        <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA        = st_reg.rdata;
  assign PINS             = st_reg.pins;
  assign EXTRA_OUTPUT_PIN = st_reg.xtra;
  assign IRQ              = st_reg.irq;

endmodule : gpe_port

// ==== gpe_port_checker.sv ====
// assertions on the pin port's top-level ports.
// assumes one clock domain and synchronous active-high reset.
`timescale 1ns/1ps
module gpe_port_checker #(
  parameter int unsigned N_PINS = gpe_pkg::NPINS
) (
  input wire logic                      CLK,
  input wire logic                      RESET,
  input wire gpe_pkg::gpe_req_t         REG_REQ,
  input wire logic [gpe_pkg::DW-1:0]    REG_RDATA,
  input wire logic [gpe_pkg::NPINS-1:0] PIN_IN,
  input wire logic [gpe_pkg::NPINS-1:0] PIN_SEL,
  input wire gpe_pkg::gpe_pins_t        PINS,
  input wire logic                      EXTRA_OUTPUT_PIN,
  input wire logic                      IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_wr(logic [gpe_pkg::AW-1:0] a);
    REG_REQ.wr && REG_REQ.addr == a;
  endsequence
  AST_RD_IDLE: assert property (!$past(REG_REQ.rd) |-> REG_RDATA == '0)
    else $error("read data outside read slot");
  AST_OE_SEL: assert property ((PINS.oe & ~$past(PIN_SEL)) == '0)
    else $error("unselected pin driven");
  AST_OUT_OE: assert property ((PINS.out & ~PINS.oe) == '0)
    else $error("output level on undriven pin");
  AST_DIR_WR: assert property (s_wr(gpe_pkg::OFS_DIR) |=>
    PINS.oe == ($past(REG_REQ.wdata) & $past(PIN_SEL)))
    else $error("direction write not applied");
  AST_DOUT_WR: assert property (s_wr(gpe_pkg::OFS_DOUT) |=>
    PINS.out == ($past(REG_REQ.wdata) & PINS.oe))
    else $error("output write not applied");
  AST_XTRA_WR: assert property (s_wr(gpe_pkg::OFS_XTRA) |=>
    EXTRA_OUTPUT_PIN == $past(REG_REQ.wdata[0]))
    else $error("extra pin write not applied");
  AST_PD_WR: assert property (s_wr(gpe_pkg::OFS_PDD) |=>
    PINS.pd_en == (~$past(REG_REQ.wdata) & $past(PIN_SEL)))
    else $error("pull-down write not applied");
  AST_IRQ_RISE: assert property ($rose(IRQ) |-> $past(REG_REQ.wr) ||
    $past(PIN_IN, 2) != $past(PIN_IN, 4))
    else $error("interrupt without cause");
  AST_IRQ_HOLD: assert property (IRQ && !REG_REQ.wr |=> IRQ)
    else $error("interrupt dropped without write");
endmodule : gpe_port_checker

// ==== gpe_port_test.sv ====
// self-checking bench for the pin port.
// assumes the pad model and checker files are compiled first.
`timescale 1ns/1ps
module gpe_port_test;
  logic               clk;
  logic               reset;
  gpe_pkg::gpe_req_t  req;
  gpe_pkg::gpe_pins_t pins;
  logic [31:0]        rdata, pin_in, pin_sel, ext_en, ext_val;
  logic               xpin, irq;
  int                 failures, n_tests;

  gpe_port dut (.CLK(clk), .RESET(reset), .REG_REQ(req), .REG_RDATA(rdata),
    .PIN_IN(pin_in), .PIN_SEL(pin_sel), .PINS(pins),
    .EXTRA_OUTPUT_PIN(xpin), .IRQ(irq));
  gpe_pad_model pad (.pins(pins), .ext_en(ext_en), .ext_val(ext_val),
    .pin_lvl(pin_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    #1 check(rdata, e);
  endtask : rd

  task automatic t_reset;
    check(pins.pd_en, 32'hffff_ffff);
    check({pins.oe[30:0], irq}, 32'h0);
    for (int i = 0; i < 8; i++)
      rd(6'(4 * i), 32'h0);
    rd(6'h3c, 32'h0);
  endtask : t_reset

  task automatic t_out;
    wr(gpe_pkg::OFS_DIR, 32'hffff_ffff);
    wr(gpe_pkg::OFS_DOUT, 32'ha5a5_5a5a);
    check(pins.out, 32'ha5a5_5a5a);
    wr(gpe_pkg::OFS_SET, 32'h000f_ffff);
    check(pins.out, 32'ha5af_ffff);
    wr(gpe_pkg::OFS_CLR, 32'h0000_ff0f);
    check(pins.out, 32'ha5af_00f0);
    pin_sel <= 32'hffff_fffe;
    wr(6'h3c, 32'h0);
    check(pins.oe, 32'hffff_fffe);
    wr(gpe_pkg::OFS_XTRA, 32'h1);
    check({31'h0, xpin}, 32'h1);
    rd(gpe_pkg::OFS_DOUT, 32'ha5af_00f0);
    pin_sel <= 32'hffff_ffff;
  endtask : t_out

  task automatic t_in;
    wr(gpe_pkg::OFS_DIR, 32'hffff_0000);
    ext_en <= 32'h0000_ffff;
    ext_val <= 32'h0000_3c96;
    repeat (3) @(posedge clk);
    rd(gpe_pkg::OFS_DIN, 32'h0000_3c96);
    wr(gpe_pkg::OFS_PDD, 32'h0000_ff00);
    check(pins.pd_en, 32'hffff_00ff);
    wr(gpe_pkg::OFS_PDD, 32'h0);
  endtask : t_in

  task automatic t_irq;
    ext_val <= 32'h2;
    wr(gpe_pkg::OFS_POL, 32'h2);
    repeat (4) @(posedge clk);
    wr(gpe_pkg::OFS_IFR, 32'hffff_ffff);
    wr(gpe_pkg::OFS_IER, 32'h7);
    ext_val <= 32'hd;
    @(posedge clk);
    ext_val <= 32'h9;
    @(posedge clk);
    ext_val <= 32'h2;
    repeat (4) @(posedge clk);
    #1 check({31'h0, irq}, 32'h1);
    rd(gpe_pkg::OFS_IFR, 32'hb);
    wr(gpe_pkg::OFS_IFR, 32'h3);
    check({31'h0, irq}, 32'h0);
    rd(gpe_pkg::OFS_IFR, 32'h8);
    wr(gpe_pkg::OFS_IER, 32'h8);
    check({31'h0, irq}, 32'h1);
    wr(gpe_pkg::OFS_IFR, 32'h8);
    check({31'h0, irq}, 32'h0);
  endtask : t_irq

  task automatic complete_run;
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #100000;
    failures++;
    complete_run;
  end
  initial begin
    reset = 1'b1;
    req = '0;
    pin_sel = '1;
    ext_en = '0;
    ext_val = '0;
    failures = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_reset;
    t_out;
    t_in;
    t_irq;
    complete_run;
  end
endmodule : gpe_port_test

bind gpe_port gpe_port_checker #(.N_PINS(N_PINS)) u_chk (.CLK(CLK),
  .RESET(RESET), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .PIN_IN(PIN_IN),
  .PIN_SEL(PIN_SEL), .PINS(PINS), .EXTRA_OUTPUT_PIN(EXTRA_OUTPUT_PIN),
  .IRQ(IRQ));
